// file: rtl/cosl_consts.svh
`ifndef COSL_CONSTS_SVH
`define COSL_CONSTS_SVH
`define COSL_ID_W 11
`define COSL_FC_HI 10
`define COSL_FC_LO 7
`define COSL_NODE_HI 6
`define COSL_ID_NMT 11'h000
`define COSL_ID_SYNC 11'h080
`define COSL_ID_EMCY_BASE 11'h080
`define COSL_ID_TPDO1 11'h181
`define COSL_ID_TPDO2 11'h281
`define COSL_ID_TPDO3 11'h381
`define COSL_ID_TPDO4 11'h481
`define COSL_ID_RPDO1 11'h201
`define COSL_ID_RPDO2 11'h301
`define COSL_ID_RPDO3 11'h401
`define COSL_ID_RPDO4 11'h501
`define COSL_ID_TSDO 11'h581
`define COSL_ID_RSDO 11'h601
`define COSL_ID_GUARD 11'h701
`define COSL_NMT_PREOP 8'h80
`define COSL_NMT_START 8'h01
`define COSL_NMT_STOP 8'h02
`define COSL_NMT_RSTNODE 8'h81
`define COSL_NMT_RSTCOMM 8'h82
`define COSL_NMT_DLC 4'h2
`define COSL_SYNC_DLC 4'h0
`define COSL_EMCY_DLC 4'h8
`define COSL_TT_ACYC 8'h00
`define COSL_TT_SYNC 8'h01
`define COSL_TT_CYC_MAX 8'hf0
`define COSL_TT_ONCE 8'hff
`define COSL_TT_RESET 8'hff
`define COSL_MAX_DLC 4'h8
`endif

// file: rtl/cosl_pkg.sv
package cosl_pkg;
   typedef enum logic [2:0] {
      COSL_INIT, COSL_PREOP, COSL_OPER, COSL_STOPPED, COSL_RESET
   } cosl_nmt_state_t;
   typedef struct packed {
      logic [10:0] id;
      logic rtr;
      logic [3:0] dlc;
      logic [63:0] data;
   } cosl_frame_t;
endpackage

// file: rtl/cosl_buf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cosl_buf_if;
   import cosl_pkg::*;
   logic valid;
   logic ready;
   cosl_frame_t frame;
   modport src (output valid, output frame, input ready);
   modport snk (input valid, input frame, output ready);
endinterface
`default_nettype wire

// file: rtl/cosl_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module cosl_skid_buf
   import cosl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   cosl_buf_if.snk inP,
   cosl_buf_if.src outP
);
   // Two-entry queue, slot 0 is the head
   cosl_frame_t slot_q [2];
   logic [1:0] count_q;
   wire pushOk = inP.valid && (count_q != 2'h2);
   wire popOk = outP.ready && (count_q != 2'h0);
   assign inP.ready = (count_q != 2'h2);
   assign outP.valid = (count_q != 2'h0);
   assign outP.frame = slot_q[0];

   // Occupancy
   always_ff @(posedge clk_sys) begin
      if (srst) count_q <= 2'h0;
      else count_q <= count_q + {1'b0, pushOk} - {1'b0, popOk};
   end

   // Storage shift on pop, write behind the head
   always_ff @(posedge clk_sys) begin
      if (popOk) slot_q[0] <= slot_q[1];
      if (pushOk) begin
         if (count_q == 2'h0 || (count_q == 2'h1 && popOk)) slot_q[0] <= inP.frame;
         else slot_q[count_q[0]] <= inP.frame;
      end
   end

   a_buf_no_over: assert property (@(posedge clk_sys) disable iff (srst)
      count_q <= 2'h2) else $error("buffer overfilled");
   // Head must hold while the reader stalls
   a_buf_hold: assert property (@(posedge clk_sys) disable iff (srst)
      outP.valid && !outP.ready |=> outP.valid && $stable(outP.frame))
      else $error("head lost while stalled");
endmodule
`default_nettype wire

// file: rtl/cosl_comm.sv
`timescale 1ns/10ps
`default_nettype none
`include "cosl_consts.svh"
// Overview of operation
// - Identifier: bits 10..7 function code, bits 6..0 node address.
// - Broadcasts use address zero; peer objects use addresses 1 to 127.
// - Transmit process data at 181h/281h/381h/481h plus node minus one.
// - Accept receive process data at 201h/301h/401h/501h plus node minus one.
// - Service requests at 601h, offset by node; no replies are generated.
// - Frame: identifier, RTR bit, 4-bit length, zero to eight data bytes.
// - Management commands on identifier 00h; never answered.
// - Management frame: command byte then target address; zero means all.
// - Boot and 80h enter pre-operational: service yes, process data no.
// - 01h goes operational from pre-operational only: process data and SYNC enabled.
// - Entering operational sends every object with type 255.
// - 02h enters stopped: no service, no process data, SYNC ignored.
// - 81h re-initialises communication as a node reset; a pending emergency stays latched.
// - 82h re-initialises communication and clears the guarding toggle.
// - SYNC is 80h with length zero and triggers transmit objects.
// - SYNC sends an object only with type 1 while operational.
// - Types live in sub-object 2 of 1800..1803, writable by service data.
// - Legal types: 0, 1 to 240, and 255.
// - Errors in pre-operational or operational send emergency 80h plus node with eight data bytes.
module cosl_comm
   import cosl_pkg::*;
#(
   parameter int NUM_TPDO = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [6:0] nodeId,
   input wire logic rxValid,
   input wire logic [10:0] rxId,
   input wire logic rxRtr,
   input wire logic [3:0] rxDlc,
   input wire logic [63:0] rxData,
   input wire logic [1:0] ttWrIdx,
   input wire logic [7:0] ttWrValue,
   input wire logic ttWrStb,
   input wire logic [63:0] tpdoData [4],
   input wire logic errEvent,
   input wire logic [63:0] errPayload,
   output logic txValid,
   input wire logic txReady,
   output logic [10:0] txId,
   output logic txRtr,
   output logic [3:0] txDlc,
   output logic [63:0] txData,
   output logic [2:0] nmtState,
   output logic [3:0] rpdoStb,
   output logic [63:0] rpdoData,
   output logic sdoReqStb,
   output logic [63:0] sdoReqData,
   output logic ttWrReject,
   output logic guardToggle,
   output logic commResetStb
);
   // Only four transmit objects are decoded
   if (NUM_TPDO != 4) $error("NUM_TPDO must be 4");

   // Checks below all run on the system clock
   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   cosl_nmt_state_t state_q, state_d;
   logic [7:0] ttype_q [4];
   logic [3:0] pendSync_q, pendOnce_q, pendErr_q;
   logic errPend_q;
   logic [63:0] errData_q;
   logic [3:0] rpdoStb_q;
   logic [63:0] rpdoData_q, sdoData_q;
   logic sdoStb_q, rej_q, tog_q, crst_q;
   logic [2:0] nmtState_q;

   // Identifier fields and receive decode
   wire [3:0] rxFunc = rxId[`COSL_FC_HI:`COSL_FC_LO];
   wire [6:0] rxNode = rxId[`COSL_NODE_HI:0];
   wire [10:0] nodeOff = {4'h0, nodeId} - 11'h001;
   wire nodeOk = nodeId != 7'h00;
   wire [7:0] cmdByte = rxData[7:0];
   wire [7:0] addrByte = rxData[15:8];
   wire isNmt = rxValid && {rxFunc, rxNode} == `COSL_ID_NMT && !rxRtr;
   wire nmtHit = isNmt && rxDlc == `COSL_NMT_DLC &&
      (addrByte == 8'h00 || addrByte == {1'b0, nodeId});
   wire isSync = rxValid && {rxFunc, rxNode} == `COSL_ID_SYNC &&
      rxDlc == `COSL_SYNC_DLC;
   wire guardReq = rxValid && nodeOk && rxRtr &&
      rxId == `COSL_ID_GUARD + nodeOff;
   wire syncAct = isSync && state_q == COSL_OPER;
   wire sdoHit = rxValid && nodeOk && !rxRtr &&
      rxId == `COSL_ID_RSDO + nodeOff &&
      (state_q == COSL_PREOP || state_q == COSL_OPER);
   wire dlcOk = rxDlc <= `COSL_MAX_DLC;
   wire [3:0] rpdoHit;
   assign rpdoHit[0] = rxId == `COSL_ID_RPDO1 + nodeOff;
   assign rpdoHit[1] = rxId == `COSL_ID_RPDO2 + nodeOff;
   assign rpdoHit[2] = rxId == `COSL_ID_RPDO3 + nodeOff;
   assign rpdoHit[3] = rxId == `COSL_ID_RPDO4 + nodeOff;
   wire rpdoAct = rxValid && nodeOk && !rxRtr && dlcOk &&
      state_q == COSL_OPER;
   wire ttLegal = ttWrValue <= `COSL_TT_CYC_MAX ||
      ttWrValue == `COSL_TT_ONCE;
   wire ttWrOk = ttWrStb && ttLegal;
   wire enterOper = state_q != COSL_OPER && state_d == COSL_OPER;
   wire nmtLive = state_q != COSL_INIT && state_q != COSL_RESET;
   wire doReset = nmtHit && nmtLive && (cmdByte == `COSL_NMT_RSTNODE ||
      cmdByte == `COSL_NMT_RSTCOMM);
   wire [10:0] tpdoBase [4];
   assign tpdoBase[0] = `COSL_ID_TPDO1;
   assign tpdoBase[1] = `COSL_ID_TPDO2;
   assign tpdoBase[2] = `COSL_ID_TPDO3;
   assign tpdoBase[3] = `COSL_ID_TPDO4;

   // Management state machine; boot starts in initialisation, then pre-operational
   always_comb begin
      state_d = state_q;
      case (state_q)
         COSL_INIT: state_d = COSL_PREOP;
         COSL_RESET: state_d = COSL_PREOP;
         default: begin
            if (nmtHit) begin
               case (cmdByte)
                  `COSL_NMT_PREOP: state_d = COSL_PREOP;
                  `COSL_NMT_START: begin
                     if (state_q == COSL_PREOP) state_d = COSL_OPER;
                  end
                  `COSL_NMT_STOP: state_d = COSL_STOPPED;
                  `COSL_NMT_RSTNODE: state_d = COSL_RESET;
                  `COSL_NMT_RSTCOMM: state_d = COSL_RESET;
                  default: state_d = state_q;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) state_q <= COSL_INIT;
      else state_q <= state_d;
   end

   // Transmission types, sub-object 2 of the four parameter objects
   always_ff @(posedge clk_sys) begin
      if (srst || doReset) begin
         for (int i = 0; i < 4; i++) ttype_q[i] <= `COSL_TT_RESET;
      end else if (ttWrOk) begin
         ttype_q[ttWrIdx] <= ttWrValue;
      end
   end

   // Per-object send requests from SYNC and from entering operational
   logic [3:0] syncSel, onceSel;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         syncSel[i] = syncAct && ttype_q[i] == `COSL_TT_SYNC;
         onceSel[i] = enterOper && ttype_q[i] == `COSL_TT_ONCE;
      end
   end

   // Transmit arbitration: emergency first, then lowest object
   cosl_buf_if txIn();
   cosl_buf_if txOut();
   logic [3:0] pend;
   logic [1:0] pick;
   logic anyPend;
   assign pend = pendSync_q | pendOnce_q;
   always_comb begin
      pick = 2'h0;
      anyPend = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 2'(i);
            anyPend = 1'b1;
         end
      end
   end
   wire sendErr = errPend_q && nodeOk;
   wire canSend = state_q == COSL_OPER || state_q == COSL_PREOP;
   assign txIn.valid = sendErr || (anyPend && state_q == COSL_OPER);
   wire txTake = txIn.valid && txIn.ready;
   wire tookPdo = txTake && !sendErr;
   always_comb begin
      txIn.frame.rtr = 1'b0;
      if (sendErr) begin
         txIn.frame.id = `COSL_ID_EMCY_BASE + {4'h0, nodeId};
         txIn.frame.dlc = `COSL_EMCY_DLC;
         txIn.frame.data = errData_q;
      end else begin
         txIn.frame.id = tpdoBase[pick] + nodeOff;
         txIn.frame.dlc = `COSL_MAX_DLC;
         txIn.frame.data = tpdoData[pick];
      end
   end

   // Pending flags; a new trigger wins over the clear
   always_ff @(posedge clk_sys) begin
      if (srst || doReset || state_q != COSL_OPER) begin
         pendSync_q <= 4'h0;
         pendOnce_q <= onceSel;
      end else begin
         for (int i = 0; i < 4; i++) begin
            pendSync_q[i] <= syncSel[i] ||
               (pendSync_q[i] && !(tookPdo && pick == 2'(i)));
            pendOnce_q[i] <= pendOnce_q[i] && !(tookPdo && pick == 2'(i) &&
               !pendSync_q[i]);
         end
      end
   end

   // Emergency request latch
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         errPend_q <= 1'b0;
         errData_q <= 64'h0;
      end else if (errEvent && canSend) begin
         errPend_q <= 1'b1;
         errData_q <= errPayload;
      end else if (txTake && sendErr) begin
         errPend_q <= 1'b0;
      end
   end

   cosl_skid_buf u_txbuf (
      .clk_sys(clk_sys),
      .srst(srst),
      .inP(txIn),
      .outP(txOut)
   );
   assign txOut.ready = txReady && txValid;

   // Registered transmit outputs, follow the buffer head
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         txValid <= 1'b0;
         txId <= 11'h0;
         txRtr <= 1'b0;
         txDlc <= 4'h0;
         txData <= 64'h0;
      end else if (!txValid || txReady) begin
         txValid <= txOut.valid && !(txValid && txReady);
         txId <= txOut.frame.id;
         txRtr <= txOut.frame.rtr;
         txDlc <= txOut.frame.dlc;
         txData <= txOut.frame.data;
      end
   end

   // Received data delivery and status
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rpdoStb_q <= 4'h0;
         rpdoData_q <= 64'h0;
         sdoStb_q <= 1'b0;
         sdoData_q <= 64'h0;
         rej_q <= 1'b0;
         tog_q <= 1'b0;
         crst_q <= 1'b0;
         nmtState_q <= 3'h0;
      end else begin
         rpdoStb_q <= rpdoAct ? rpdoHit : 4'h0;
         if (rpdoAct) rpdoData_q <= rxData;
         sdoStb_q <= sdoHit;
         if (sdoHit) sdoData_q <= rxData;
         rej_q <= ttWrStb && !ttLegal;
         if (doReset) tog_q <= 1'b0;
         else if (guardReq) tog_q <= !tog_q;
         crst_q <= doReset;
         nmtState_q <= 3'(state_d);
      end
   end
   assign rpdoStb = rpdoStb_q;
   assign rpdoData = rpdoData_q;
   assign sdoReqStb = sdoStb_q;
   assign sdoReqData = sdoData_q;
   assign ttWrReject = rej_q;
   assign guardToggle = tog_q;
   assign commResetStb = crst_q;
   assign nmtState = nmtState_q;

   // Protocol checks on decode, state and transmit path
   a_nmt_no_reply: assert property (nmtHit |->
      !(txIn.valid && txIn.frame.id == `COSL_ID_NMT))
      else $error("reply on management id");
   a_stop_no_pdo: assert property (state_q == COSL_STOPPED |->
      ##1 rpdoStb == 4'h0 && !sdoReqStb) else $error("traffic while stopped");
   a_start_oper: assert property (nmtHit && cmdByte == 8'h01 &&
      state_q == COSL_PREOP |=> state_q == COSL_OPER)
      else $error("start ignored");
   a_preop_entry: assert property (nmtHit && nmtLive &&
      cmdByte == 8'h80 |=> state_q == COSL_PREOP) else $error("pre-op missed");
   a_reset_path: assert property (doReset |=>
      state_q == COSL_RESET ##1 state_q == COSL_PREOP)
      else $error("reset path wrong");
   a_tt_reject: assert property (ttWrStb && !ttLegal &&
      !doReset |=> ttype_q[$past(ttWrIdx)] == $past(ttype_q[ttWrIdx]))
      else $error("illegal type stored");
   a_sync_sends: assert property (syncAct &&
      ttype_q[0] == 8'h01 |=> pendSync_q[0]) else $error("sync not queued");
   a_bad_nmt: assert property (isNmt && rxDlc != 4'h2 &&
      state_q == COSL_OPER |=> state_q == COSL_OPER)
      else $error("bad nmt acted");
   a_once_entry: assert property (enterOper &&
      ttype_q[1] == 8'hff |=> pendOnce_q[1]) else $error("once object lost");
   a_emcy_id: assert property (txTake && sendErr |->
      txIn.frame.id == 11'h080 + {4'h0, nodeId} && txIn.frame.dlc == 4'h8)
      else $error("bad emergency");
   c_go_oper: cover property (@(posedge clk_sys) state_q == COSL_OPER);
   c_sync_tx: cover property (@(posedge clk_sys) syncAct ##[1:20] txValid);
   c_stall: cover property (@(posedge clk_sys) txValid && !txReady && !txIn.ready);
   c_reset: cover property (@(posedge clk_sys) doReset);
endmodule
`default_nettype wire

// file: tb/cosl_nmt_master.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the management master: sends frames, stalls, logs replies
module cosl_nmt_master
   import cosl_pkg::*;
(
   input wire logic clk_sys,
   output logic rxValid,
   output logic [10:0] rxId,
   output logic rxRtr,
   output logic [3:0] rxDlc,
   output logic [63:0] rxData,
   output logic txReady,
   input wire logic txValid,
   input wire logic [10:0] txId,
   input wire logic [3:0] txDlc,
   input wire logic [63:0] txData
);
   logic [78:0] txQ[$];

   // Idle bus state at time zero
   initial begin
      rxValid = 1'b0;
      rxId = 11'h7ff;
      rxRtr = 1'b1;
      rxDlc = 4'hf;
      rxData = 64'h0;
      txReady = 1'b0;
   end

   // Identifier, RTR, length, payload; stale fields scrambled after
   task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                       input logic [63:0] d);
      @(negedge clk_sys);
      rxId = id;
      rxRtr = 1'b0;
      rxDlc = dlc;
      rxData = d;
      rxValid = 1'b1;
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxId = ~id;
      rxDlc = ~dlc;
      rxData = ~d;
   endtask

   // Broadcast command: byte0 command, byte1 target, never answered
   task automatic nmt(input logic [7:0] cmd, input logic [6:0] addr);
      send(11'h000, 4'h2, {48'h0, 1'b0, addr, cmd});
   endtask

   // SYNC with zero length
   task automatic sync();
      send(11'h080, 4'h0, 64'h0);
   endtask

   // Guarding request: remote frame, flips the slave toggle
   task automatic guard(input logic [10:0] id);
      @(negedge clk_sys);
      rxId = id;
      rxRtr = 1'b1;
      rxDlc = 4'h0;
      rxValid = 1'b1;
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxId = ~id;
   endtask

   // Random stalls on the transmit side
   always @(negedge clk_sys) txReady <= ($urandom_range(0, 2) != 0);

   // Log every accepted transmit frame
   always @(posedge clk_sys) begin
      if (txValid && txReady) txQ.push_back({txId, txDlc, txData});
   end
endmodule
`default_nettype wire

// file: tb/canopen_slave_nmt_pdo_comm_tb.sv
`timescale 1ns/10ps
`default_nettype none
module canopen_slave_nmt_pdo_comm_tb;
   import cosl_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [6:0] nodeId;
   logic rxValid, rxRtr, txReady, ttWrStb, errEvent, txValid, txRtr;
   logic sdoReqStb, ttWrReject, guardToggle, commResetStb;
   logic [10:0] rxId, txId;
   logic [3:0] rxDlc, txDlc, rpdoStb;
   logic [63:0] rxData, txData, errPayload, rpdoData, sdoReqData, d;
   logic [63:0] tpdoData [4];
   logic [1:0] ttWrIdx;
   logic [7:0] ttWrValue;
   logic [2:0] nmtState;
   logic [7:0] tt [8];
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int rpSeen [4];
   int sdoSeen, rejSeen, crSeen;

   cosl_comm i_cosl_comm (.clk_sys, .srst, .nodeId, .rxValid, .rxId,
      .rxRtr, .rxDlc, .rxData, .ttWrIdx, .ttWrValue, .ttWrStb, .tpdoData,
      .errEvent, .errPayload, .txValid, .txReady, .txId, .txRtr, .txDlc,
      .txData, .nmtState, .rpdoStb, .rpdoData, .sdoReqStb, .sdoReqData,
      .ttWrReject, .guardToggle, .commResetStb);
   cosl_nmt_master i_cosl_nmt_master (.clk_sys, .rxValid, .rxId, .rxRtr,
      .rxDlc, .rxData, .txReady, .txValid, .txId, .txDlc, .txData);

   always #5 clk_sys = ~clk_sys;

   // Count strobes; hang guard
   always @(posedge clk_sys) begin
      for (int k = 0; k < 4; k++) if (rpdoStb[k] === 1'b1) rpSeen[k]++;
      if (sdoReqStb === 1'b1) sdoSeen++;
      if (ttWrReject === 1'b1) rejSeen++;
      if (commResetStb === 1'b1) crSeen++;
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         end_of_test();
      end
   end

   // Identifiers: function code above, node address below
   function automatic logic [10:0] tpId(input int k);
      return 11'h181 + 11'(k) * 11'h100 + 11'(nodeId) - 11'h1;
   endfunction
   function automatic logic [10:0] rpId(input int k);
      return 11'h201 + 11'(k) * 11'h100 + 11'(nodeId) - 11'h1;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic clr();
      rpSeen = '{0, 0, 0, 0};
      sdoSeen = 0;
      rejSeen = 0;
      crSeen = 0;
   endtask
   task automatic done(input string s);
      $display("Test %s finished at %0t", s, $time);
   endtask
   task automatic txWait(input int n);
      for (int i = 0; i < 200 && i_cosl_nmt_master.txQ.size() < n; i++) wt(1);
      wt(20);
      chk(i_cosl_nmt_master.txQ.size(), n);
   endtask
   task automatic txExp(input logic [10:0] id, input logic [63:0] dat);
      logic [78:0] f;
      f = i_cosl_nmt_master.txQ.pop_front();
      chk(f[78:68], id);
      chk(f[67:64], 4'h8);
      chk(f[63:0], dat);
   endtask
   // Service-data write of one transmission type
   task automatic ttW(input logic [1:0] i, input logic [7:0] v);
      @(negedge clk_sys);
      ttWrIdx = i;
      ttWrValue = v;
      ttWrStb = 1'b1;
      @(negedge clk_sys);
      ttWrStb = 1'b0;
      wt(2);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(42136));
      nodeId = 7'($urandom_range(1, 127));
      for (int k = 0; k < 4; k++) tpdoData[k] = {$urandom, $urandom};
      ttWrIdx = 2'h0;
      ttWrValue = 8'h0;
      ttWrStb = 1'b0;
      errEvent = 1'b0;
      errPayload = 64'h0;
      tt = '{8'h01, 8'h00, 8'hf0, 8'hff, 8'hf1, 8'hfe, 8'hf7, 8'h00};
      tt[7] = 8'($urandom_range(241, 254));
      clr();
      wt(3);
      srst = 1'b0;
      wt(3);
      chk(nmtState, 3'h1);
      chk(txValid, 1'b0);
      done("reset");
      d = {$urandom, $urandom};
      i_cosl_nmt_master.send(rpId(0), 4'h8, d);
      i_cosl_nmt_master.send(11'h600 + 11'(nodeId), 4'h8, d);
      i_cosl_nmt_master.sync();
      wt(30);
      chk(rpSeen[0], 0);
      chk(sdoSeen, 1);
      chk(sdoReqData, d);
      chk(i_cosl_nmt_master.txQ.size(), 0);
      i_cosl_nmt_master.send(11'h000, 4'h3, {48'h0, 1'b0, nodeId, 8'h01});
      i_cosl_nmt_master.nmt(8'h01, (nodeId == 7'h7f) ? 7'h01 : nodeId + 7'h1);
      wt(4);
      chk(nmtState, 3'h1);
      done("preop");
      i_cosl_nmt_master.nmt(8'h01, nodeId);
      wt(4);
      chk(nmtState, 3'h2);
      txWait(4);
      for (int k = 0; k < 4; k++) txExp(tpId(k), tpdoData[k]);
      chk(txRtr, 1'b0);
      done("start");
      for (int k = 0; k < 8; k++) ttW(2'(k), tt[k]);
      chk(rejSeen, 4);
      ttW(2'h2, 8'h01);
      i_cosl_nmt_master.sync();
      i_cosl_nmt_master.sync();
      txWait(4);
      for (int k = 0; k < 4; k++) txExp(tpId(k % 2 * 2), tpdoData[k % 2 * 2]);
      done("sync");
      for (int k = 0; k < 4; k++) begin
         clr();
         d = {$urandom, $urandom};
         i_cosl_nmt_master.send(rpId(k), 4'h8, d);
         wt(3);
         chk(rpSeen[k], 1);
         chk(rpdoData, d);
      end
      d = {$urandom, $urandom};
      @(negedge clk_sys);
      errPayload = d;
      errEvent = 1'b1;
      @(negedge clk_sys);
      errEvent = 1'b0;
      txWait(1);
      txExp(11'h080 + 11'(nodeId), d);
      done("oper");
      clr();
      i_cosl_nmt_master.nmt(8'h02, 7'h00);
      wt(4);
      chk(nmtState, 3'h3);
      i_cosl_nmt_master.sync();
      i_cosl_nmt_master.send(11'h600 + 11'(nodeId), 4'h8, d);
      i_cosl_nmt_master.send(rpId(1), 4'h8, d);
      wt(30);
      chk(i_cosl_nmt_master.txQ.size(), 0);
      chk(sdoSeen, 0);
      chk(rpSeen[1], 0);
      done("stop");
      for (int k = 0; k < 2; k++) begin
         clr();
         ttW(2'h0, 8'h01);
         i_cosl_nmt_master.guard(11'h700 + 11'(nodeId));
         wt(2);
         chk(guardToggle, 1'b1);
         i_cosl_nmt_master.nmt(8'h81 + 8'(k), nodeId);
         wt(4);
         chk(nmtState, 3'h1);
         chk(guardToggle, 1'b0);
         chk(crSeen, 1);
         i_cosl_nmt_master.nmt(8'h01, 7'h00);
         txWait(4);
         i_cosl_nmt_master.txQ.delete();
      end
      i_cosl_nmt_master.nmt(8'h80, 7'h00);
      wt(4);
      chk(nmtState, 3'h1);
      done("resets");
      end_of_test();
   end
endmodule
`default_nettype wire
